// *** hdl/down_timer_three_pwm.sv ***
// 10-bit down timer with prescaler, underflow flag and three shared-period pwm channels
//
// Behaviour
// [RULE_01] 10-bit counter decrements per prescaled tick
// [RULE_02] running: reload buffered, applied at underflow
// [RULE_03] stopped: low reload write loads counter
// [RULE_04] count register reads the live counter
// [RULE_05] control one bit 0 starts/stops timer
// [RULE_06] control two bit 5 selects external pin
// [RULE_07] edge bit 4: one falling, zero rising
// [RULE_08] prescaler when bit 3 low, 1:2..1:256
// [RULE_09] prescaler count readable, read only
// [RULE_10] one-shot counts down once, then stops
// [RULE_11] continuous reload from buffer or 0x3FF
// [RULE_12] sticky underflow flag, gated interrupt request
// [RULE_13] channel one enable drives its pin
// [RULE_14] channel one polarity bit 6
// [RULE_15] duty zero inactive, 0x3FF gives 1023 ticks
// [RULE_16] firmware keeps duty within reload value
// [RULE_17] channel one duty high first, applied underflow
// [RULE_18] channel two own bits, shared high 3:2
// [RULE_19] firmware mirrors timer bits into channel two
// [RULE_20] channel three dedicated high register bits 1:0
// [RULE_21] firmware mirrors timer bits into channel three
// [RULE_22] active first duty ticks, restart each reload
//
// The register offsets and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ps
module down_timer_three_pwm
    import dtp_pkg::*;
#(
    parameter int WIDTH = TIMER_W
) (
    input  wire logic              clock,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic      [31:0]       readdata,
    output logic                   waitrequest,
    input  wire logic              external_count_pin,
    input  wire logic              global_irq_enable,
    output logic                   irq_request,
    output logic      [2:0]        pwm_out,
    output logic      [2:0]        pwm_oe
);
    logic [7:0]         ctrl_one_reg;
    logic [7:0]         ctrl_two_reg;
    logic [7:0]         shared_hi_reg;
    logic [7:0]         ch1_duty_reg;
    logic [7:0]         ch2_ctrl_reg;
    logic [7:0]         ch2_duty_reg;
    logic [7:0]         ch3_ctrl_reg;
    logic [7:0]         ch3_duty_h_reg;
    logic [7:0]         ch3_duty_reg;
    logic [7:0]         reload_low_reg;
    logic [WIDTH-1:0]   count_reg;
    logic [WIDTH-1:0]   frame_start_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic               pin_prev_reg;
    logic               stopped_reg;
    logic               flag_reg;
    logic               irq_en_reg;
    logic [IDX_W-1:0]   idx;
    logic               access;
    logic               wr;
    logic               run;
    logic               src_tick;
    logic               tick;
    logic               underflow;
    logic [2:0]         ratio;
    logic [PRESC_W-1:0] presc_mask;
    logic [WIDTH-1:0]   reload_buf;
    logic [WIDTH-1:0]   elapsed;
    logic [31:0]        rd_mux;
    logic [WIDTH-1:0]   duty_buf   [3];
    logic [2:0]         chan_oen;
    logic [2:0]         chan_low;

    if (WIDTH != TIMER_W) begin : g_bad_width
        $error("timer width must be 10");
    end

    // avalon slave: one wait cycle, access done when waitrequest is low
    assign idx    = address[IDX_LSB +: IDX_W];
    assign access = (read || write) && !waitrequest;
    assign wr     = access && write && byteenable[0];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            waitrequest <= 1'b1;
            readdata    <= WORD_ZERO;
        end else if (clk_en) begin
            if ((read || write) && waitrequest) begin
                waitrequest <= 1'b0;
                readdata    <= rd_mux;
            end else begin
                waitrequest <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_mux = WORD_ZERO;
        case (idx)
            IDX_CTRL_ONE:   rd_mux[7:0] = ctrl_one_reg;
            IDX_CTRL_TWO:   rd_mux[7:0] = ctrl_two_reg;
            IDX_COUNT_LOW:  rd_mux[7:0] = count_reg[7:0];                     // [RULE_04]
            IDX_COUNT_HIGH: rd_mux[1:0] = count_reg[WIDTH-1:8];               // [RULE_04]
            IDX_SHARED_HI:  rd_mux[7:0] = shared_hi_reg;
            IDX_CH1_DUTY:   rd_mux[7:0] = ch1_duty_reg;
            IDX_CH2_CTRL:   rd_mux[7:0] = ch2_ctrl_reg;
            IDX_CH2_DUTY:   rd_mux[7:0] = ch2_duty_reg;
            IDX_CH3_CTRL:   rd_mux[7:0] = ch3_ctrl_reg;
            IDX_CH3_DUTY_H: rd_mux[7:0] = ch3_duty_h_reg;
            IDX_CH3_DUTY:   rd_mux[7:0] = ch3_duty_reg;
            IDX_PRESC_VAL:  rd_mux[7:0] = presc_reg;                          // [RULE_09]
            IDX_IRQ_TWO: begin
                rd_mux[B_IRQ_FLAG]   = flag_reg;
                rd_mux[B_IRQ_ENABLE] = irq_en_reg;
            end
            default:        rd_mux = WORD_ZERO;
        endcase
    end

    // plain read/write control and duty buffers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one_reg   <= BYTE_ZERO;
            ctrl_two_reg   <= CTRL_TWO_RST;
            shared_hi_reg  <= BYTE_ZERO;
            ch1_duty_reg   <= BYTE_ZERO;
            ch2_ctrl_reg   <= BYTE_ZERO;
            ch2_duty_reg   <= BYTE_ZERO;
            ch3_ctrl_reg   <= BYTE_ZERO;
            ch3_duty_h_reg <= BYTE_ZERO;
            ch3_duty_reg   <= BYTE_ZERO;
            reload_low_reg <= BYTE_ZERO;
            irq_en_reg     <= 1'b0;
        end else if (clk_en && wr) begin
            case (idx)
                IDX_CTRL_ONE:   ctrl_one_reg   <= writedata[7:0];             // [RULE_05]
                IDX_CTRL_TWO:   ctrl_two_reg   <= writedata[7:0];
                IDX_COUNT_LOW:  reload_low_reg <= writedata[7:0];             // [RULE_02]
                IDX_SHARED_HI:  shared_hi_reg  <= writedata[7:0];             // [RULE_17] [RULE_18]
                IDX_CH1_DUTY:   ch1_duty_reg   <= writedata[7:0];
                IDX_CH2_CTRL:   ch2_ctrl_reg   <= writedata[7:0];
                IDX_CH2_DUTY:   ch2_duty_reg   <= writedata[7:0];
                IDX_CH3_CTRL:   ch3_ctrl_reg   <= writedata[7:0];
                IDX_CH3_DUTY_H: ch3_duty_h_reg <= writedata[7:0];             // [RULE_20]
                IDX_CH3_DUTY:   ch3_duty_reg   <= writedata[7:0];
                IDX_IRQ_TWO:    irq_en_reg     <= writedata[B_IRQ_ENABLE];
                default:        irq_en_reg     <= irq_en_reg;
            endcase
        end
    end

    assign reload_buf = {shared_hi_reg[F_RELOAD_HI_H:F_RELOAD_HI_L], reload_low_reg};
    assign duty_buf[0] = {shared_hi_reg[F_CH1_HI_H:F_CH1_HI_L], ch1_duty_reg};
    assign duty_buf[1] = {shared_hi_reg[F_CH2_HI_H:F_CH2_HI_L], ch2_duty_reg};
    assign duty_buf[2] = {ch3_duty_h_reg[F_CH1_HI_H:F_CH1_HI_L], ch3_duty_reg};
    assign chan_oen = {ch3_ctrl_reg[B_OUT_ENABLE], ch2_ctrl_reg[B_OUT_ENABLE], ctrl_one_reg[B_OUT_ENABLE]};
    assign chan_low = {ch3_ctrl_reg[B_ACTIVE_LOW], ch2_ctrl_reg[B_ACTIVE_LOW], ctrl_one_reg[B_ACTIVE_LOW]};

    // clock source: instruction clock or an edge of the external pin
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_reg <= 1'b0;
        end else if (clk_en) begin
            pin_prev_reg <= external_count_pin;
        end
    end

    assign run = ctrl_one_reg[B_RUN] && !stopped_reg;                         // [RULE_05]

    always_comb begin
        if (!ctrl_two_reg[B_CLOCK_SEL]) begin
            src_tick = run;                                                   // [RULE_06]
        end else if (ctrl_two_reg[B_EDGE_SEL]) begin
            src_tick = run && pin_prev_reg && !external_count_pin;            // [RULE_07]
        end else begin
            src_tick = run && !pin_prev_reg && external_count_pin;            // [RULE_07]
        end
    end

    // ratio n divides by 2^(n+1): tick when the low n+1 bits roll over
    assign ratio      = ctrl_two_reg[F_RATIO_HI:F_RATIO_LO];
    assign presc_mask = PRESC_W'((9'h002 << ratio) - 9'h001);
    assign tick       = ctrl_two_reg[B_PRESC_EN_N] ? src_tick
                      : (src_tick && ((presc_reg & presc_mask) == presc_mask)); // [RULE_08]

    // prescaler restarts whenever its configuration is rewritten
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            presc_reg <= '0;
        end else if (clk_en) begin
            if (wr && idx == IDX_CTRL_TWO) begin
                presc_reg <= '0;                                              // [RULE_08]
            end else if (src_tick && !ctrl_two_reg[B_PRESC_EN_N]) begin
                presc_reg <= presc_reg + PRESC_W'(1);                         // [RULE_09]
            end
        end
    end

    assign underflow = tick && (count_reg == COUNT_ZERO);

    // counter: decrement, reload on underflow unless one-shot, immediate load when stopped
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg       <= COUNT_FULL;
            frame_start_reg <= COUNT_FULL;
        end else if (clk_en) begin
            if (wr && idx == IDX_COUNT_LOW && !ctrl_one_reg[B_RUN]) begin
                count_reg       <= {shared_hi_reg[F_RELOAD_HI_H:F_RELOAD_HI_L], writedata[7:0]}; // [RULE_03]
                frame_start_reg <= {shared_hi_reg[F_RELOAD_HI_H:F_RELOAD_HI_L], writedata[7:0]};
            end else if (underflow && !ctrl_one_reg[B_ONE_SHOT]) begin
                count_reg       <= ctrl_one_reg[B_RELOAD_SEL] ? reload_buf : COUNT_FULL; // [RULE_11] [RULE_02]
                frame_start_reg <= ctrl_one_reg[B_RELOAD_SEL] ? reload_buf : COUNT_FULL; // [RULE_22]
            end else if (tick && !underflow) begin
                count_reg <= count_reg - WIDTH'(1);                           // [RULE_01]
            end
        end
    end

    // one-shot halt holds the counter at zero until control one or the count low register is written
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stopped_reg <= 1'b0;
        end else if (clk_en) begin
            if (underflow && ctrl_one_reg[B_ONE_SHOT]) begin
                stopped_reg <= 1'b1;                                          // [RULE_10]
            end else if (wr && (idx == IDX_CTRL_ONE || idx == IDX_COUNT_LOW)) begin
                stopped_reg <= 1'b0;
            end
        end
    end

    // sticky flag: an underflow in the clearing cycle wins
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            flag_reg <= 1'b0;
        end else if (clk_en) begin
            if (underflow) begin
                flag_reg <= 1'b1;                                             // [RULE_12]
            end else if (wr && idx == IDX_IRQ_TWO && !writedata[B_IRQ_FLAG]) begin
                flag_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_request <= 1'b0;
        end else if (clk_en) begin
            irq_request <= flag_reg && irq_en_reg && global_irq_enable;       // [RULE_12]
        end
    end

    // duty bound is firmware's job; an oversize duty simply stays active all frame
    assign elapsed = frame_start_reg - count_reg;                             // [RULE_22] [RULE_16]

    for (genvar i = 0; i < 3; i++) begin : g_chan
        pwm_channel #(
            .W          (WIDTH)
        ) u_chan (
            .clock      (clock),
            .rst_n      (rst_n),
            .clk_en     (clk_en),
            .commit     (underflow),                                          // [RULE_17] [RULE_18] [RULE_20]
            .duty_buf   (duty_buf[i]),
            .elapsed    (elapsed),
            .out_enable (chan_oen[i]),                                        // [RULE_13]
            .active_low (chan_low[i]),                                        // [RULE_14] [RULE_15]
            .pwm_out    (pwm_out[i]),
            .pwm_oe     (pwm_oe[i])
        );
    end

    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_tick_live;
        clk_en && tick && count_reg != COUNT_ZERO;
    endsequence

    sequence s_wrap(logic sel);
        clk_en && underflow && !ctrl_one_reg[B_ONE_SHOT] && ctrl_one_reg[B_RELOAD_SEL] == sel
            && !(wr && idx == IDX_COUNT_LOW && !ctrl_one_reg[B_RUN]);
    endsequence

    sequence s_low_write_stopped;
        clk_en && wr && idx == IDX_COUNT_LOW && !ctrl_one_reg[B_RUN];
    endsequence

    sequence s_flag_clear;
        clk_en && wr && idx == IDX_IRQ_TWO && !writedata[B_IRQ_FLAG] && !underflow;
    endsequence

    AST_DECREMENT: assert property (s_tick_live |=> count_reg == $past(count_reg) - WIDTH'(1)) // [RULE_01]
        else $error("counter did not decrement on tick");

    AST_WRAP_FULL: assert property (s_wrap(1'b0) |=> count_reg == COUNT_FULL) // [RULE_11]
        else $error("continuous wrap did not restart from full");

    AST_WRAP_BUF: assert property (s_wrap(1'b1) |=> count_reg == $past(reload_buf)) // [RULE_02]
        else $error("continuous wrap did not take reload buffer");

    AST_ONE_SHOT: assert property (clk_en && underflow && ctrl_one_reg[B_ONE_SHOT] && !wr // [RULE_10]
                                   |=> stopped_reg && count_reg == COUNT_ZERO)
        else $error("one-shot did not stop at zero");

    AST_IMMEDIATE_LOAD: assert property (s_low_write_stopped // [RULE_03]
                                         |=> count_reg == {$past(shared_hi_reg[5:4]), $past(writedata[7:0])})
        else $error("stopped timer did not load written value");

    AST_FLAG_IRQ: assert property (clk_en && underflow ##1 clk_en && irq_en_reg && global_irq_enable // [RULE_12]
                                   && !(wr && idx == IDX_IRQ_TWO)
                                   |=> flag_reg && irq_request)
        else $error("underflow did not raise flag and request");

    AST_HOLD_STOPPED: assert property (clk_en && !ctrl_one_reg[B_RUN] && !wr |=> $stable(count_reg)) // [RULE_05]
        else $error("counter moved while timer disabled");

    AST_BUS_ANSWER: assert property ((read || write) && waitrequest && clk_en |=> !waitrequest ##1 waitrequest) // [RULE_04]
        else $error("bus answer not one cycle after request");

    AST_FLAG_CLEAR: assert property (s_flag_clear |=> !flag_reg) // [RULE_12]
        else $error("flag not cleared by zero write");

    AST_IRQ_GATE: assert property (clk_en && !global_irq_enable |=> !irq_request) // [RULE_12]
        else $error("request without global enable");

    AST_PRESC_CLEAR: assert property (clk_en && wr && idx == IDX_CTRL_TWO |=> presc_reg == '0) // [RULE_08]
        else $error("prescaler not cleared on control two write");

    AST_PIN_OFF: assert property (clk_en && !ctrl_one_reg[B_OUT_ENABLE] |=> !pwm_out[0] && !pwm_oe[0]) // [RULE_13]
        else $error("channel one drives while disabled");

    AST_FREEZE: assert property (!clk_en |=> $stable(count_reg) && $stable(presc_reg)) // [RULE_01]
        else $error("state moved while clock enable low");
endmodule

// *** hdl/dtp_pkg.sv ***
// constants shared by the down-counting timer and its pwm channels
package dtp_pkg;
    localparam int          TIMER_W        = 10;
    localparam int          PRESC_W        = 8;
    localparam int          ADDR_W         = 6;
    localparam int          IDX_LSB        = 2;
    localparam int          IDX_W          = 4;
    // register word indices, byte address is four times the index
    localparam logic [3:0]  IDX_CTRL_ONE   = 4'h0;
    localparam logic [3:0]  IDX_CTRL_TWO   = 4'h1;
    localparam logic [3:0]  IDX_COUNT_LOW  = 4'h2;
    localparam logic [3:0]  IDX_SHARED_HI  = 4'h3;
    localparam logic [3:0]  IDX_CH1_DUTY   = 4'h4;
    localparam logic [3:0]  IDX_CH2_CTRL   = 4'h5;
    localparam logic [3:0]  IDX_CH2_DUTY   = 4'h6;
    localparam logic [3:0]  IDX_CH3_CTRL   = 4'h7;
    localparam logic [3:0]  IDX_CH3_DUTY_H = 4'h8;
    localparam logic [3:0]  IDX_CH3_DUTY   = 4'h9;
    localparam logic [3:0]  IDX_PRESC_VAL  = 4'hA;
    localparam logic [3:0]  IDX_IRQ_TWO    = 4'hB;
    localparam logic [3:0]  IDX_COUNT_HIGH = 4'hC;
    // control one / channel control fields
    localparam int          B_RUN          = 0;
    localparam int          B_RELOAD_SEL   = 1;
    localparam int          B_ONE_SHOT     = 2;
    localparam int          B_ACTIVE_LOW   = 6;
    localparam int          B_OUT_ENABLE   = 7;
    // control two fields
    localparam int          B_CLOCK_SEL    = 5;
    localparam int          B_EDGE_SEL     = 4;
    localparam int          B_PRESC_EN_N   = 3;
    localparam int          F_RATIO_HI     = 2;
    localparam int          F_RATIO_LO     = 0;
    // shared high bits fields
    localparam int          F_RELOAD_HI_H  = 5;
    localparam int          F_RELOAD_HI_L  = 4;
    localparam int          F_CH2_HI_H     = 3;
    localparam int          F_CH2_HI_L     = 2;
    localparam int          F_CH1_HI_H     = 1;
    localparam int          F_CH1_HI_L     = 0;
    // second interrupt register fields
    localparam int          B_IRQ_FLAG     = 4;
    localparam int          B_IRQ_ENABLE   = 0;
    localparam logic [9:0]  COUNT_FULL     = 10'h3FF;
    localparam logic [9:0]  COUNT_ZERO     = 10'h000;
    localparam logic [7:0]  BYTE_ZERO      = 8'h00;
    localparam logic [7:0]  CTRL_TWO_RST   = 8'h08;
    localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
endpackage

// *** hdl/pwm_channel.sv ***
// one pwm channel: double-buffered duty and registered pin drive
`timescale 1ns/1ps
module pwm_channel
    import dtp_pkg::*;
#(
    parameter int W = 10
) (
    input  wire logic         clock,
    input  wire logic         rst_n,
    input  wire logic         clk_en,
    input  wire logic         commit,
    input  wire logic [W-1:0] duty_buf,
    input  wire logic [W-1:0] elapsed,
    input  wire logic         out_enable,
    input  wire logic         active_low,
    output logic              pwm_out,
    output logic              pwm_oe
);
    logic [W-1:0] duty_reg;
    logic         active;

    if (W < 2) begin : g_bad_width
        $error("pwm_channel width too small");
    end

    // new duty only at the timer underflow, so a frame never sees half an update
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            duty_reg <= '0;
        end else if (clk_en && commit) begin
            duty_reg <= duty_buf;
        end
    end

    // active for the first duty ticks of each frame; duty zero never active
    assign active = (elapsed < duty_reg);                          // [RULE_15] [RULE_22]

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_out <= 1'b0;
            pwm_oe  <= 1'b0;
        end else if (clk_en) begin
            pwm_oe  <= out_enable;
            pwm_out <= out_enable & (active ^ active_low);
        end
    end
endmodule

// *** test/down_timer_three_pwm_tb.sv ***
// self-checking bench for the down timer and its three pwm channels
`timescale 1ns/1ps
module down_timer_three_pwm_tb
    import dtp_pkg::*;
;
    logic              clock;
    logic              rst_n;
    logic              clk_en;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
    logic [31:0]       readdata;
    logic              waitrequest;
    logic              pin;
    logic              pin_busy;
    logic              tog_start;
    logic [9:0]        tog_n;
    logic [1:0]        dwell;
    logic              global_irq_enable;
    logic              irq_request;
    logic [2:0]        pwm_out;
    logic [2:0]        pwm_oe;
    int                mismatches;
    int                checks_done;
    logic [7:0]        q;
    logic [9:0]        cnt;
    logic [9:0]        e;
    logic [9:0]        r;

    down_timer_three_pwm #(.WIDTH(TIMER_W)) u_down_timer_three_pwm (
        .clock(clock), .rst_n(rst_n), .clk_en(clk_en), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .external_count_pin(pin), .global_irq_enable(global_irq_enable), .irq_request(irq_request),
        .pwm_out(pwm_out), .pwm_oe(pwm_oe));

    pin_toggle_model u_pin_toggle_model (
        .clock(clock), .rst_n(rst_n), .start(tog_start), .toggles(tog_n), .dwell(dwell),
        .pin(pin), .busy(pin_busy));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task automatic wrap_up();
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [15:0] act_exp(input logic [9:0] d, input int f);
        return 16'(d * f);
    endfunction

    // request held until waitrequest is seen low; an edge passes before the next one
    task automatic bus(input logic wr, input logic [3:0] idx, input logic [7:0] d, input logic [3:0] be);
        int n;
        n = 0;
        address    <= {idx, 2'b00};
        write      <= wr;
        read       <= ~wr;
        writedata  <= {{24{1'b0}}, d};
        byteenable <= be;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40) mismatches++;
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [3:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d, 4'h1);
    endtask

    task automatic rdc();
        bus(1'b0, IDX_COUNT_LOW, 8'h00, 4'hF);
        cnt[7:0] = q;
        bus(1'b0, IDX_COUNT_HIGH, 8'h00, 4'hF);
        cnt[9:8] = q[1:0];
    endtask

    task automatic tog(input logic [9:0] n);
        int k;
        k = 0;
        tog_n     <= n;
        dwell     <= 2'($urandom_range(0, 3));
        tog_start <= 1'b1;
        @(posedge clock);
        tog_start <= 1'b0;
        do begin
            @(posedge clock);
            k++;
        end while (pin_busy && k < 5000);
        repeat (4) @(posedge clock);
    endtask

    task automatic pwm_run(input logic [9:0] rl, input logic [9:0] d1, input logic [9:0] d2,
                           input logic [9:0] d3, input logic [2:0] al, input int frames);
        int act [3];
        act = '{0, 0, 0};
        wr(IDX_CTRL_TWO, 8'h08);
        wr(IDX_CTRL_ONE, 8'h00);
        wr(IDX_SHARED_HI, {2'b00, rl[9:8], d2[9:8], d1[9:8]});
        wr(IDX_CH1_DUTY, d1[7:0]);
        wr(IDX_CH2_DUTY, d2[7:0]);
        wr(IDX_CH3_DUTY_H, {6'h00, d3[9:8]});
        wr(IDX_CH3_DUTY, d3[7:0]);
        wr(IDX_CH2_CTRL, {1'b1, al[1], 6'h03});
        wr(IDX_CH3_CTRL, {1'b1, al[2], 6'h03});
        wr(IDX_COUNT_LOW, rl[7:0]);
        wr(IDX_CTRL_ONE, {1'b1, al[0], 6'h03});
        // duties commit only at the first underflow, so let two frames pass
        repeat (2 * rl + 20) @(posedge clock);
        repeat ((rl + 1) * frames) begin
            @(posedge clock);
            for (int i = 0; i < 3; i++) if (pwm_out[i] !== al[i]) act[i]++;
        end
        chk(16'(act[0]), act_exp(d1, frames));
        chk(16'(act[1]), act_exp(d2, frames));
        chk(16'(act[2]), act_exp(d3, frames));
        chk({13'h0000, pwm_oe}, 16'h0007);
    endtask

    initial begin
        repeat (60000) @(posedge clock);
        mismatches++;
        wrap_up();
    end

    initial begin
        mismatches = 0;
        checks_done = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'h0;
        tog_start = 1'b0;
        tog_n = 10'h000;
        dwell = 2'h0;
        global_irq_enable = 1'b0;
        void'($urandom(32'h43f4));
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        bus(1'b1, IDX_CTRL_ONE, 8'hFF, 4'h0);
        for (int i = 0; i < 14; i++) begin
            bus(1'b0, 4'(i), 8'h00, 4'hF);
            chk({8'h00, q}, (i == 1) ? 16'h0008 : (i == 2) ? 16'h00FF : (i == 12) ? 16'h0003 : 16'h0000);
        end
        r = 10'($urandom_range(16, 1023));
        wr(IDX_SHARED_HI, {2'b00, r[9:8], 4'h0});
        wr(IDX_COUNT_LOW, r[7:0]);
        rdc();
        chk(cnt, r);
        wr(IDX_CTRL_TWO, 8'h28);
        wr(IDX_CTRL_ONE, 8'h01);
        rdc();
        chk(cnt, r);
        e = r - 10'($urandom_range(1, 6));
        tog(2 * (r - e));
        rdc();
        chk(cnt, e);
        tog(1);
        wr(IDX_CTRL_TWO, 8'h38);
        tog(1);
        rdc();
        chk(cnt, e - 10'h002);
        tog(1);
        rdc();
        chk(cnt, e - 10'h002);
        wr(IDX_CTRL_ONE, 8'h00);
        tog(5);
        rdc();
        chk(cnt, e - 10'h002);
        wr(IDX_SHARED_HI, 8'h30);
        wr(IDX_COUNT_LOW, 8'h00);
        wr(IDX_CTRL_ONE, 8'h01);
        e = 10'h300;
        for (int n = 0; n < 8; n++) begin
            wr(IDX_CTRL_TWO, {5'b00100, 3'(n)});
            tog(10'(4 << n));
            e = e - 10'h001;
            rdc();
            chk(cnt, e);
            bus(1'b0, IDX_PRESC_VAL, 8'h00, 4'hF);
            chk({8'h00, q}, 16'((2 << n) & 255));
        end
        wr(IDX_PRESC_VAL, 8'hA5);
        bus(1'b0, IDX_PRESC_VAL, 8'h00, 4'hF);
        chk({8'h00, q}, 16'h0000);
        wr(IDX_CTRL_TWO, 8'h28);
        wr(IDX_CTRL_ONE, 8'h00);
        wr(IDX_SHARED_HI, 8'h00);
        e = 10'($urandom_range(2, 9));
        wr(IDX_COUNT_LOW, e[7:0]);
        wr(IDX_IRQ_TWO, 8'h01);
        wr(IDX_CTRL_ONE, 8'h05);
        tog(2 * e);
        rdc();
        chk(cnt, 10'h000);
        bus(1'b0, IDX_IRQ_TWO, 8'h00, 4'hF);
        chk({8'h00, q}, 16'h0001);
        tog(6);
        rdc();
        chk(cnt, 10'h000);
        bus(1'b0, IDX_IRQ_TWO, 8'h00, 4'hF);
        chk({8'h00, q}, 16'h0011);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge clock);
        chk({15'h0000, irq_request}, 16'h0001);
        wr(IDX_IRQ_TWO, 8'h01);
        repeat (3) @(posedge clock);
        chk({15'h0000, irq_request}, 16'h0000);
        wr(IDX_CTRL_ONE, 8'h00);
        wr(IDX_COUNT_LOW, 8'h02);
        wr(IDX_CTRL_ONE, 8'h01);
        tog(8);
        rdc();
        chk(cnt, 10'h3FE);
        wr(IDX_CTRL_ONE, 8'h00);
        wr(IDX_COUNT_LOW, 8'h02);
        wr(IDX_CTRL_ONE, 8'h03);
        e = 10'($urandom_range(3, 255));
        wr(IDX_COUNT_LOW, e[7:0]);
        rdc();
        chk(cnt, 10'h002);
        tog(8);
        rdc();
        chk(cnt, e - 10'h001);
        // edges while the clock enable is low must be lost
        clk_en <= 1'b0;
        tog(4);
        clk_en <= 1'b1;
        rdc();
        chk(cnt, e - 10'h001);
        r = 10'($urandom_range(8, 40));
        // duties stay within the reload value
        pwm_run(r, 10'($urandom_range(0, r)), 10'($urandom_range(0, r)), r, 3'($urandom), 4);
        pwm_run(10'h3FF, 10'h3FF, 10'h000, 10'h001, 3'b010, 1);
        wr(IDX_CTRL_ONE, 8'h00);
        repeat (3) @(posedge clock);
        chk({14'h0000, pwm_oe[0], pwm_out[0]}, 16'h0000);
        wrap_up();
    end
endmodule

// *** test/pin_toggle_model.sv ***
// far-side model: drives the external count pin in bursts of toggles
`timescale 1ns/1ps
module pin_toggle_model (
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       start,
    input  wire logic [9:0] toggles,
    input  wire logic [1:0] dwell,
    output logic            pin,
    output logic            busy
);
    logic [9:0] left_reg;
    logic [1:0] wait_reg;

    // pin parks at its last level between bursts; dwell stretches each level
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            left_reg <= 10'h000;
            wait_reg <= 2'h0;
            pin      <= 1'b0;
        end else if (start) begin
            left_reg <= toggles;
            wait_reg <= 2'h0;
        end else if (left_reg != 10'h000) begin
            wait_reg <= wait_reg + 2'h1;
            if (wait_reg == dwell) begin
                wait_reg <= 2'h0;
                pin      <= ~pin;
                left_reg <= left_reg - 10'h001;
            end
        end
    end

    assign busy = (left_reg != 10'h000);
endmodule
